// *** shared/cfef_map.svh ***
// Register offsets, field positions, reset values and timing defaults of the charger event flags
`ifndef CFEF_MAP_SVH
`define CFEF_MAP_SVH

`define CFEF_ADDR_W 8
`define CFEF_DATA_W 8
`define CFEF_OFS_THERM_FLAGS 8'h25
`define CFEF_OFS_FAULT_A 8'h26
`define CFEF_OFS_FAULT_B 8'h27
`define CFEF_OFS_IRQ_MASK 8'h28
`define CFEF_RST_VAL 8'h00
`define CFEF_READ_UNMAPPED 8'h00

// Battery and thermal event flags
`define CFEF_TF_BATLOW 4
`define CFEF_TF_COLD 3
`define CFEF_TF_COOL 2
`define CFEF_TF_WARM 1
`define CFEF_TF_HOT 0
`define CFEF_TF_USED 8'h1F
`define CFEF_TF_BOTH 8'h0F

// Protection fault flags A
`define CFEF_FA_IBAT_REG 7
`define CFEF_FA_BUS_OV 6
`define CFEF_FA_BAT_OV 5
`define CFEF_FA_IN_OC 4
`define CFEF_FA_DIS_OC 3
`define CFEF_FA_CONV_OC 2
`define CFEF_FA_IN2_OV 1
`define CFEF_FA_IN1_OV 0
`define CFEF_FA_USED 8'hFF
`define CFEF_FA_BOTH 8'h80

// Protection fault flags B
`define CFEF_FB_SYS_SHORT 7
`define CFEF_FB_SYS_OV 6
`define CFEF_FB_REV_OV 5
`define CFEF_FB_REV_UV 4
`define CFEF_FB_TSHUT 2
`define CFEF_FB_USED 8'hF4
`define CFEF_FB_BOTH 8'h00

// Interrupt mask fields
`define CFEF_MK_CURR 7
`define CFEF_MK_VOLT 6
`define CFEF_MK_WDOG 5
`define CFEF_MK_WEAK 4
`define CFEF_MK_PGOOD 3
`define CFEF_MK_IN2 2
`define CFEF_MK_IN1 1
`define CFEF_MK_BUS 0
`define CFEF_MK_USED 8'hFF
`define CFEF_MK_BOTH 8'h0F

`define CFEF_IRQ_PULSE_CYC 16

`endif

// *** shared/cfef_pkg.sv ***
// Types shared by the charger event flag block
package cfef_pkg;

  typedef logic [7:0] cfef_byte_type;

  typedef enum logic [1:0] {
    CFEF_IRQ_IDLE,
    CFEF_IRQ_PULSE,
    CFEF_IRQ_GAP
  } cfef_irq_state_type;

endpackage : cfef_pkg

// *** rtl/cfef_event_latch.sv ***
// Edge detector with sticky, clear-on-read event flags
`timescale 1ns/1ps
`default_nettype none
`include "cfef_map.svh"

module cfef_event_latch #(
  parameter int W = 8,
  parameter logic [W-1:0] BOTH = '0,
  parameter logic [W-1:0] USED = '1
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] cond_i,
  input wire logic clear_i,
  output logic [W-1:0] events_o,
  output logic [W-1:0] flags_o
);
  import cfef_pkg::*;

  logic [W-1:0] prev_r;
  logic [W-1:0] flags_r;
  logic primed_r;

  // First cycle after reset only learns the levels, so a condition
  // already present at power-up is not reported as a transition
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      primed_r <= 1'b0;
    end else begin
      primed_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      prev_r <= '0;
    end else begin
      prev_r <= cond_i;
    end
  end

  assign events_o = ((cond_i & ~prev_r) | (~cond_i & prev_r & BOTH)) & USED & {W{primed_r}};

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      flags_r <= '0;
    end else begin
      flags_r <= (flags_r & ~{W{clear_i}}) | events_o; // R20
    end
  end

  assign flags_o = flags_r;

endmodule // cfef_event_latch

`default_nettype wire

// *** rtl/cfef_top.sv ***
// Charger event flags, fault flags and interrupt mask with pulsed interrupt
//
// Operation
// [R1] Flag registers are read-only, eight bits, zero at reset; one means event seen.
// [R2] Flag bit 4 sets when battery drops too low for reverse-source mode.
// [R3] Flag bits 3..0 set on cold, cool, warm and hot thermistor crossings.
// [R4] Fault A bit 7 sets on entering or leaving battery current regulation.
// [R5] Fault A bits 6, 1, 0 set on bus, second and first input overvoltage.
// [R6] Fault A bit 5 sets on entering battery overvoltage protection.
// [R7] Fault A bits 4, 3, 2 set on input, discharge and converter overcurrent.
// [R8] Fault B bit 7 sets when switching stops on a system rail short.
// [R9] Fault B bit 6 sets when switching stops on system rail overvoltage.
// [R10] Fault B bits 5, 4 set when reverse output stops on bus over/undervoltage.
// [R11] Fault B bit 2 sets on thermal shutdown; bits 3, 1, 0 read zero.
// [R12] Entering current regulation pulses the interrupt unless mask bit 7 is set.
// [R13] Entering voltage regulation pulses the interrupt unless mask bit 6 is set.
// [R14] Watchdog expiry pulses the interrupt unless mask bit 5 is set.
// [R15] Weak source detection pulses the interrupt unless mask bit 4 is set.
// [R16] Power-good toggle pulses the interrupt unless mask bit 3 is set.
// [R17] Second input presence change pulses the interrupt unless mask bit 2 is set.
// [R18] First input presence change pulses the interrupt unless mask bit 1 is set.
// [R19] Mask register is read/write, eight bits, zero at reset.
// [R20] A flag register clears when read; set flags hold until then.
// [R21] The register-reset command returns all mask bits to zero.
`timescale 1ns/1ps
`default_nettype none
`include "cfef_map.svh"

module cfef_top #(
  parameter int IRQ_PULSE_CYCLES = `CFEF_IRQ_PULSE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [`CFEF_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire cfef_pkg::cfef_byte_type reg_wdata_i,
  output cfef_pkg::cfef_byte_type reg_rdata_o,
  input wire logic reg_reset_i,
  input wire logic battery_low_for_reverse_output_i,
  input wire logic thermistor_cold_i,
  input wire logic thermistor_cool_i,
  input wire logic thermistor_warm_i,
  input wire logic thermistor_hot_i,
  input wire logic battery_current_regulation_i,
  input wire logic input_bus_overvoltage_i,
  input wire logic battery_overvoltage_i,
  input wire logic input_current_overcurrent_i,
  input wire logic battery_discharge_overcurrent_i,
  input wire logic converter_overcurrent_i,
  input wire logic second_input_overvoltage_i,
  input wire logic first_input_overvoltage_i,
  input wire logic system_rail_short_i,
  input wire logic system_rail_overvoltage_i,
  input wire logic reverse_output_overvoltage_i,
  input wire logic reverse_output_undervoltage_i,
  input wire logic thermal_shutdown_i,
  input wire logic current_regulation_i,
  input wire logic voltage_regulation_i,
  input wire logic bus_watchdog_expired_i,
  input wire logic weak_source_detected_i,
  input wire logic power_good_i,
  input wire logic second_input_present_i,
  input wire logic first_input_present_i,
  input wire logic input_bus_present_i,
  output logic irq_n_o
);
  import cfef_pkg::*;

  localparam int CNT_W = $clog2(IRQ_PULSE_CYCLES + 1);

  cfef_byte_type therm_cond;
  cfef_byte_type fault_a_cond;
  cfef_byte_type fault_b_cond;
  cfef_byte_type irq_cond;
  cfef_byte_type therm_flags;
  cfef_byte_type fault_a_flags;
  cfef_byte_type fault_b_flags;
  cfef_byte_type fault_a_events;
  cfef_byte_type irq_events;
  cfef_byte_type irq_unmasked;
  cfef_byte_type mask_r;
  cfef_byte_type rdata_r;
  logic rd_therm;
  logic rd_fault_a;
  logic rd_fault_b;
  logic wr_mask;
  logic pending_r;
  logic [CNT_W-1:0] pulse_cnt_r;
  cfef_irq_state_type state_r;

  // --------------------------------------------------------------
  // Event sources
  // --------------------------------------------------------------
  always_comb begin
    therm_cond = '0;
    therm_cond[`CFEF_TF_BATLOW] = battery_low_for_reverse_output_i; // R2
    therm_cond[`CFEF_TF_COLD] = thermistor_cold_i; // R3
    therm_cond[`CFEF_TF_COOL] = thermistor_cool_i; // R3
    therm_cond[`CFEF_TF_WARM] = thermistor_warm_i; // R3
    therm_cond[`CFEF_TF_HOT] = thermistor_hot_i; // R3
  end

  always_comb begin
    fault_a_cond = '0;
    fault_a_cond[`CFEF_FA_IBAT_REG] = battery_current_regulation_i; // R4
    fault_a_cond[`CFEF_FA_BUS_OV] = input_bus_overvoltage_i; // R5
    fault_a_cond[`CFEF_FA_BAT_OV] = battery_overvoltage_i; // R6
    fault_a_cond[`CFEF_FA_IN_OC] = input_current_overcurrent_i; // R7
    fault_a_cond[`CFEF_FA_DIS_OC] = battery_discharge_overcurrent_i; // R7
    fault_a_cond[`CFEF_FA_CONV_OC] = converter_overcurrent_i; // R7
    fault_a_cond[`CFEF_FA_IN2_OV] = second_input_overvoltage_i; // R5
    fault_a_cond[`CFEF_FA_IN1_OV] = first_input_overvoltage_i; // R5
  end

  // Reserved positions stay zero so they never latch
  always_comb begin
    fault_b_cond = '0;
    fault_b_cond[`CFEF_FB_SYS_SHORT] = system_rail_short_i; // R8
    fault_b_cond[`CFEF_FB_SYS_OV] = system_rail_overvoltage_i; // R9
    fault_b_cond[`CFEF_FB_REV_OV] = reverse_output_overvoltage_i; // R10
    fault_b_cond[`CFEF_FB_REV_UV] = reverse_output_undervoltage_i; // R10
    fault_b_cond[`CFEF_FB_TSHUT] = thermal_shutdown_i; // R11
  end

  always_comb begin
    irq_cond = '0;
    irq_cond[`CFEF_MK_CURR] = current_regulation_i;
    irq_cond[`CFEF_MK_VOLT] = voltage_regulation_i;
    irq_cond[`CFEF_MK_WDOG] = bus_watchdog_expired_i;
    irq_cond[`CFEF_MK_WEAK] = weak_source_detected_i;
    irq_cond[`CFEF_MK_PGOOD] = power_good_i;
    irq_cond[`CFEF_MK_IN2] = second_input_present_i;
    irq_cond[`CFEF_MK_IN1] = first_input_present_i;
    irq_cond[`CFEF_MK_BUS] = input_bus_present_i;
  end

  // --------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------
  assign rd_therm = reg_rd_i && (reg_addr_i == `CFEF_OFS_THERM_FLAGS);
  assign rd_fault_a = reg_rd_i && (reg_addr_i == `CFEF_OFS_FAULT_A);
  assign rd_fault_b = reg_rd_i && (reg_addr_i == `CFEF_OFS_FAULT_B);
  assign wr_mask = reg_wr_i && (reg_addr_i == `CFEF_OFS_IRQ_MASK);

  // --------------------------------------------------------------
  // Flag registers
  // --------------------------------------------------------------
  cfef_event_latch #(
    .W(`CFEF_DATA_W),
    .BOTH(`CFEF_TF_BOTH),
    .USED(`CFEF_TF_USED)
  ) u_therm_flags (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .cond_i(therm_cond),
    .clear_i(rd_therm),
    .events_o(),
    .flags_o(therm_flags)
  );

  cfef_event_latch #(
    .W(`CFEF_DATA_W),
    .BOTH(`CFEF_FA_BOTH),
    .USED(`CFEF_FA_USED)
  ) u_fault_a_flags (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .cond_i(fault_a_cond),
    .clear_i(rd_fault_a),
    .events_o(fault_a_events),
    .flags_o(fault_a_flags)
  );

  cfef_event_latch #(
    .W(`CFEF_DATA_W),
    .BOTH(`CFEF_FB_BOTH),
    .USED(`CFEF_FB_USED)
  ) u_fault_b_flags (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .cond_i(fault_b_cond),
    .clear_i(rd_fault_b),
    .events_o(),
    .flags_o(fault_b_flags)
  );

  // Only the transition pulses matter here; the sticky copy is never cleared
  cfef_event_latch #(
    .W(`CFEF_DATA_W),
    .BOTH(`CFEF_MK_BOTH),
    .USED(`CFEF_MK_USED)
  ) u_irq_edges (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .cond_i(irq_cond),
    .clear_i(1'b0),
    .events_o(irq_events),
    .flags_o()
  );

  // --------------------------------------------------------------
  // Mask register and read data
  // --------------------------------------------------------------
  // Register reset beats a write in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mask_r <= `CFEF_RST_VAL; // R19
    end else if (reg_reset_i) begin
      mask_r <= `CFEF_RST_VAL; // R21
    end else if (wr_mask) begin
      mask_r <= reg_wdata_i; // R19
    end
  end

  // Writes to flag offsets are dropped: those registers are read-only
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= `CFEF_RST_VAL;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `CFEF_OFS_THERM_FLAGS: rdata_r <= therm_flags; // R1
        `CFEF_OFS_FAULT_A: rdata_r <= fault_a_flags; // R1
        `CFEF_OFS_FAULT_B: rdata_r <= fault_b_flags; // R1
        `CFEF_OFS_IRQ_MASK: rdata_r <= mask_r; // R19
        default: rdata_r <= `CFEF_READ_UNMAPPED;
      endcase
    end
  end

  assign reg_rdata_o = rdata_r;

  // --------------------------------------------------------------
  // Interrupt pulse
  // --------------------------------------------------------------
  assign irq_unmasked = irq_events & ~mask_r; // R12 R13 R14 R15 R16 R17 R18

  // Events during a pulse are remembered and give one more pulse, not lost
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pending_r <= 1'b0;
    end else if (|irq_unmasked) begin
      pending_r <= 1'b1;
    end else if (state_r == CFEF_IRQ_IDLE) begin
      pending_r <= 1'b0;
    end
  end

  // The gap cycle keeps back-to-back pulses distinguishable to the host
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_r <= CFEF_IRQ_IDLE;
      pulse_cnt_r <= '0;
    end else begin
      case (state_r)
        CFEF_IRQ_IDLE: begin
          if (pending_r) begin
            state_r <= CFEF_IRQ_PULSE;
            pulse_cnt_r <= CNT_W'(IRQ_PULSE_CYCLES - 1);
          end
        end
        CFEF_IRQ_PULSE: begin
          if (pulse_cnt_r == '0) begin
            state_r <= CFEF_IRQ_GAP;
          end else begin
            pulse_cnt_r <= pulse_cnt_r - 1'b1;
          end
        end
        CFEF_IRQ_GAP: begin
          state_r <= CFEF_IRQ_IDLE;
        end
        default: begin
          state_r <= CFEF_IRQ_IDLE;
        end
      endcase
    end
  end

  assign irq_n_o = (state_r != CFEF_IRQ_PULSE);

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic [CNT_W:0] low_len_r;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || irq_n_o) begin
      low_len_r <= '0;
    end else begin
      low_len_r <= low_len_r + 1'b1;
    end
  end

  property p_flags_zero_after_reset;
    $rose(rst_n_i) |-> (therm_flags == '0) && (fault_a_flags == '0) && (fault_b_flags == '0);
  endproperty
  a_flags_zero_after_reset: assert property (p_flags_zero_after_reset) // R1
    else $error("Flags not zero after reset");

  property p_batlow_sets;
    $rose(battery_low_for_reverse_output_i) && $past(rst_n_i) |=> therm_flags[`CFEF_TF_BATLOW];
  endproperty
  a_batlow_sets: assert property (p_batlow_sets) // R2
    else $error("Low battery event not latched");

  property p_hot_leave_sets;
    $fell(thermistor_hot_i) && $past(rst_n_i) |=> therm_flags[`CFEF_TF_HOT];
  endproperty
  a_hot_leave_sets: assert property (p_hot_leave_sets) // R3
    else $error("Thermistor crossing not latched");

  property p_ibat_reg_both;
    $changed(battery_current_regulation_i) && $past(rst_n_i) |=> fault_a_flags[`CFEF_FA_IBAT_REG];
  endproperty
  a_ibat_reg_both: assert property (p_ibat_reg_both) // R4
    else $error("Regulation entry or exit not latched");

  property p_bus_ov_sets;
    $rose(input_bus_overvoltage_i) && $past(rst_n_i) |=> fault_a_flags[`CFEF_FA_BUS_OV];
  endproperty
  a_bus_ov_sets: assert property (p_bus_ov_sets) // R5
    else $error("Bus overvoltage not latched");

  property p_short_sets;
    $rose(system_rail_short_i) && $past(rst_n_i) |=> fault_b_flags[`CFEF_FB_SYS_SHORT];
  endproperty
  a_short_sets: assert property (p_short_sets) // R8
    else $error("System short not latched");

  property p_reserved_zero;
    (fault_b_flags & ~`CFEF_FB_USED) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // R11
    else $error("Reserved fault bit set");

  property p_read_clears;
    rd_fault_a && (fault_a_events == '0) |=> (fault_a_flags == '0);
  endproperty
  a_read_clears: assert property (p_read_clears) // R20
    else $error("Read did not clear flags");

  property p_flags_hold;
    !rd_fault_a |=> (fault_a_flags & $past(fault_a_flags)) == $past(fault_a_flags);
  endproperty
  a_flags_hold: assert property (p_flags_hold) // R20
    else $error("Flag dropped without read");

  property p_reg_reset_mask;
    reg_reset_i |=> (mask_r == `CFEF_RST_VAL);
  endproperty
  a_reg_reset_mask: assert property (p_reg_reset_mask) // R21
    else $error("Mask not cleared by register reset");

  property p_unmasked_pulses;
    (|irq_unmasked) && (state_r == CFEF_IRQ_IDLE) && !pending_r |-> ##2 !irq_n_o;
  endproperty
  a_unmasked_pulses: assert property (p_unmasked_pulses) // R12
    else $error("Unmasked event gave no interrupt");

  property p_masked_silent;
    (mask_r == 8'hFF) && !pending_r && !reg_wr_i |=> !pending_r;
  endproperty
  a_masked_silent: assert property (p_masked_silent) // R13
    else $error("Masked event raised an interrupt");

  property p_pulse_width;
    $rose(irq_n_o) |-> low_len_r == (CNT_W + 1)'(IRQ_PULSE_CYCLES);
  endproperty
  a_pulse_width: assert property (p_pulse_width) // R14
    else $error("Interrupt pulse width wrong");

  c_irq_pulse: cover property ($fell(irq_n_o));
  c_read_clear: cover property (rd_fault_a && (fault_a_flags != '0));
  c_mask_write: cover property (wr_mask && (reg_wdata_i != '0));

endmodule // cfef_top

`default_nettype wire

// *** test/cfef_host_model.sv ***
// Host model: register access strobes and interrupt pulse measurement
`timescale 1ns/1ps
`default_nettype none

module cfef_host_model
  import cfef_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire cfef_pkg::cfef_byte_type reg_rdata_i,
  input wire logic irq_n_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output cfef_pkg::cfef_byte_type reg_wdata_o,
  output logic reg_reset_o
);
  int pulses;
  int width;
  int run;

  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_reset_o = 1'b0;
    pulses = 0;
    width = 0;
    run = 0;
  end

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  // Idle address and data are inverted so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input cfef_byte_type d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output cfef_byte_type d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask

  task automatic reg_rst();
    @(negedge sys_clk_i);
    reg_reset_o = 1'b1;
    @(negedge sys_clk_i);
    reg_reset_o = 1'b0;
  endtask

  // ----------------------------------------
  // Interrupt pulse counting
  // ----------------------------------------
  // Sampled on the falling edge, away from the edge that moves the pulse
  always @(negedge sys_clk_i) begin
    if (!rst_n_i) begin
      run = 0;
    end else if (!irq_n_i) begin
      run++;
    end else if (run != 0) begin
      pulses++;
      width = run;
      run = 0;
    end
  end
endmodule : cfef_host_model

`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the charger event flag block
`timescale 1ns/1ps
`default_nettype none
`include "cfef_map.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

module tb;
  import cfef_pkg::*;
  localparam int P = 3;
  logic sys_clk_i;
  logic rst_n_i;
  logic [23:0] ev;
  logic [7:0] src;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic reg_reset;
  cfef_byte_type reg_wdata;
  cfef_byte_type reg_rdata;
  logic irq_n;
  logic [7:0] lfsr;
  logic [23:0] pat;
  cfef_byte_type u;
  int n_mismatch;
  int comparisons;
  int base;

  cfef_top #(.IRQ_PULSE_CYCLES(P)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .reg_reset_i(reg_reset),
    .battery_low_for_reverse_output_i(ev[4]), .thermistor_cold_i(ev[3]), .thermistor_cool_i(ev[2]),
    .thermistor_warm_i(ev[1]), .thermistor_hot_i(ev[0]), .battery_current_regulation_i(ev[15]),
    .input_bus_overvoltage_i(ev[14]), .battery_overvoltage_i(ev[13]), .input_current_overcurrent_i(ev[12]),
    .battery_discharge_overcurrent_i(ev[11]), .converter_overcurrent_i(ev[10]),
    .second_input_overvoltage_i(ev[9]), .first_input_overvoltage_i(ev[8]), .system_rail_short_i(ev[23]),
    .system_rail_overvoltage_i(ev[22]), .reverse_output_overvoltage_i(ev[21]),
    .reverse_output_undervoltage_i(ev[20]), .thermal_shutdown_i(ev[18]), .current_regulation_i(src[7]),
    .voltage_regulation_i(src[6]), .bus_watchdog_expired_i(src[5]), .weak_source_detected_i(src[4]),
    .power_good_i(src[3]), .second_input_present_i(src[2]), .first_input_present_i(src[1]),
    .input_bus_present_i(src[0]), .irq_n_o(irq_n));

  cfef_host_model host_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_rdata_i(reg_rdata), .irq_n_i(irq_n),
    .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata),
    .reg_reset_o(reg_reset));

  // ----------------------------------------
  // Expectation helpers
  // ----------------------------------------
  function automatic logic [7:0] f_lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  function automatic cfef_byte_type f_used(input int g);
    return (g == 0) ? `CFEF_TF_USED : (g == 1) ? `CFEF_FA_USED : `CFEF_FB_USED;
  endfunction

  function automatic cfef_byte_type f_both(input int g);
    return (g == 0) ? `CFEF_TF_BOTH : (g == 1) ? `CFEF_FA_BOTH : `CFEF_FB_BOTH;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input cfef_byte_type exp);
    cfef_byte_type d;
    host_u.rd(a, d);
    `CHK(d, exp)
  endtask

  task automatic close_out();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // Hang guard at 40000 cycles, far beyond the roughly 840 cycles the tests need
  initial begin
    #(20 * 40000);
    n_mismatch++;
    close_out();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst_n_i = 1'b0;
    ev = '0;
    src = '0;
    lfsr = 8'h4B;
    n_mismatch = 0;
    comparisons = 0;
    repeat (8) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    cyc(3);
    for (int g = 0; g < 4; g++) begin
      rd_chk(`CFEF_OFS_THERM_FLAGS + 8'(g), `CFEF_RST_VAL);
    end
    rd_chk(8'h29, `CFEF_READ_UNMAPPED);
    $display("test reset_values done");

    repeat (8) begin
      lfsr = f_lfsr(lfsr);
      host_u.wr(`CFEF_OFS_IRQ_MASK, lfsr);
      rd_chk(`CFEF_OFS_IRQ_MASK, lfsr);
      host_u.wr(`CFEF_OFS_FAULT_A, lfsr);
      rd_chk(`CFEF_OFS_FAULT_A, 8'h00);
    end
    host_u.wr(`CFEF_OFS_IRQ_MASK, 8'hFF);
    host_u.reg_rst();
    rd_chk(`CFEF_OFS_IRQ_MASK, 8'h00);
    $display("test mask_access done");

    for (int b = 0; b < 24; b++) begin
      u = f_used(b / 8);
      if (u[b % 8]) begin
        ev[b] = 1'b1;
        cyc(2);
        rd_chk(`CFEF_OFS_THERM_FLAGS + 8'(b / 8), 8'h01 << (b % 8));
        ev[b] = 1'b0;
        cyc(2);
        u = f_both(b / 8);
        rd_chk(`CFEF_OFS_THERM_FLAGS + 8'(b / 8), u[b % 8] ? 8'h01 << (b % 8) : 8'h00);
      end
    end
    $display("test flag_bits done");

    // Conditions that end before the read must still be reported
    repeat (16) begin
      for (int g = 0; g < 3; g++) begin
        lfsr = f_lfsr(lfsr);
        pat[g*8 +: 8] = lfsr;
      end
      ev = pat;
      cyc(2);
      ev = '0;
      cyc(2);
      for (int g = 0; g < 3; g++) begin
        rd_chk(`CFEF_OFS_THERM_FLAGS + 8'(g), pat[g*8 +: 8] & f_used(g));
      end
      for (int g = 0; g < 3; g++) begin
        rd_chk(`CFEF_OFS_THERM_FLAGS + 8'(g), 8'h00);
      end
    end
    $display("test sticky_random done");

    cyc(P + 6);
    for (int k = 7; k >= 0; k--) begin
      host_u.wr(`CFEF_OFS_IRQ_MASK, ~(8'h01 << k));
      base = host_u.pulses;
      src[k] = 1'b1;
      cyc(P + 6);
      `CHK(host_u.pulses, base + 1)
      `CHK(host_u.width, P)
      host_u.wr(`CFEF_OFS_IRQ_MASK, 8'h01 << k);
      src[k] = 1'b0;
      cyc(P + 6);
      src[k] = 1'b1;
      cyc(P + 6);
      `CHK(host_u.pulses, base + 1)
      src[k] = 1'b0;
      cyc(P + 6);
    end
    // Presence and power-good changes count in both directions
    host_u.wr(`CFEF_OFS_IRQ_MASK, 8'hF0);
    base = host_u.pulses;
    src = 8'h0F;
    cyc(P + 6);
    src = 8'h00;
    cyc(P + 6);
    `CHK(host_u.pulses, base + 2)
    $display("test irq_mask done");
    close_out();
  end
endmodule : tb

`default_nettype wire
